// [hw/fepc_map.svh]
// fast ethernet pcs codec: code-groups, nibbles and timing counts
`ifndef FEPC_MAP_SVH
`define FEPC_MAP_SVH

// ===================================================================
// code-groups, five bits, sent left bit first
`define FEPC_CG_IDLE 5'h1F
`define FEPC_CG_SSD1 5'h18
`define FEPC_CG_SSD2 5'h11
`define FEPC_CG_ESD1 5'h0D
`define FEPC_CG_ESD2 5'h07
`define FEPC_CG_TXERR 5'h04
`define FEPC_CG_SLEEP 5'h00

// ===================================================================
// nibbles driven toward the mac
`define FEPC_NIB_PREAMBLE 4'h5
`define FEPC_NIB_BADSSD 4'hE

// ===================================================================
// bit timing
`define FEPC_GROUP_LAST 3'h4
`define FEPC_CLK_PERIOD_PS 5000
`define FEPC_IDLE_WINDOW_NS 40000
`define FEPC_IDLE_WINDOW_CYC \
   ((`FEPC_IDLE_WINDOW_NS * 1000) / `FEPC_CLK_PERIOD_PS)
`define FEPC_IDLE_RUN_BITS 4'hA
`define FEPC_LOCK_MATCHES 6'h1E

// ===================================================================
// lfsr taps, x^11 + x^9 + 1
`define FEPC_LFSR_W 11
`define FEPC_TAP_HI 10
`define FEPC_TAP_LO 8

`endif

// [hw/fepc_pkg.sv]
// fast ethernet pcs codec: state and level types
package fepc_pkg;

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_SSD = 4'h2,
      TX_DATA = 4'h4,
      TX_ESD = 4'h8
   } fepc_tx_state_t;

   typedef enum logic [3:0] {
      RX_HUNT = 4'h1,
      RX_GOTJ = 4'h2,
      RX_FRAME = 4'h4,
      RX_GOTT = 4'h8
   } fepc_rx_state_t;

   typedef enum logic [3:0] {
      MLT_ZERO_UP = 4'h1,
      MLT_POS = 4'h2,
      MLT_ZERO_DN = 4'h4,
      MLT_NEG = 4'h8
   } fepc_mlt_state_t;

endpackage : fepc_pkg

// [hw/fepc_lfsr.sv]
// fast ethernet pcs codec: key generator shared by scrambler and descrambler
`timescale 1ns/1ps
`default_nettype none
`include "fepc_map.svh"

module fepc_lfsr
   import fepc_pkg::*;
#(
   parameter int WIDTH = `FEPC_LFSR_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // seed taken while in reset
   input wire logic [WIDTH-1:0] seed,
   // training: shift in an observed key bit instead of feedback
   input wire logic trainEn,
   input wire logic trainBit,
   // key bit for this cycle
   output logic keyBit
);

   logic [WIDTH-1:0] state;
   logic [WIDTH-1:0] next_state;

   assign keyBit = state[`FEPC_TAP_HI] ^ state[`FEPC_TAP_LO];

   always_comb begin
      next_state = {state[WIDTH-2:0], trainEn ? trainBit : keyBit};
      if (srst) begin
         next_state = seed;
      end
   end

   always_ff @(posedge clk) begin
      state <= next_state;
   end

endmodule : fepc_lfsr
`default_nettype wire

// [hw/fepc_codec.sv]
// fast ethernet pcs codec: 4b/5b encode, scramble, mlt-3 and receive path
`timescale 1ns/1ps
`default_nettype none
`include "fepc_map.svh"

module fepc_codec
   import fepc_pkg::*;
#(
   parameter int IDLE_WINDOW_CYC = `FEPC_IDLE_WINDOW_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // management address, seeds the scrambler
   input wire logic [4:0] mgmtAddr,
   // mac transmit side
   input wire logic [3:0] txd,
   input wire logic txEn,
   input wire logic txEr,
   input wire logic txLpi,
   output logic txNibbleTake,
   // line transmit side
   output logic txCodeBit,
   output logic txNrzi,
   output logic [1:0] txMlt3,
   // line receive side, recovered level
   input wire logic [1:0] rxMlt3,
   // mac receive side
   output logic [3:0] rxd,
   output logic rxDv,
   output logic rxEr,
   output logic rxCrs,
   output logic rxNibbleStb,
   output logic rxSleep,
   output logic rxLocked
);

   // ================================================================
   // code tables
   function automatic logic [4:0] encNib(input logic [3:0] n);
      logic [4:0] g;
      g = 5'h1E;
      case (n)
         4'h0: g = 5'h1E;
         4'h1: g = 5'h09;
         4'h2: g = 5'h14;
         4'h3: g = 5'h15;
         4'h4: g = 5'h0A;
         4'h5: g = 5'h0B;
         4'h6: g = 5'h0E;
         4'h7: g = 5'h0F;
         4'h8: g = 5'h12;
         4'h9: g = 5'h13;
         4'hA: g = 5'h16;
         4'hB: g = 5'h17;
         4'hC: g = 5'h1A;
         4'hD: g = 5'h1B;
         4'hE: g = 5'h1C;
         default: g = 5'h1D;
      endcase
      return g;
   endfunction : encNib

   // returns {isData, nibble}; everything else is a control or invalid
   function automatic logic [4:0] decGrp(input logic [4:0] g);
      logic [4:0] r;
      r = 5'h00;
      case (g)
         5'h1E: r = 5'h10;
         5'h09: r = 5'h11;
         5'h14: r = 5'h12;
         5'h15: r = 5'h13;
         5'h0A: r = 5'h14;
         5'h0B: r = 5'h15;
         5'h0E: r = 5'h16;
         5'h0F: r = 5'h17;
         5'h12: r = 5'h18;
         5'h13: r = 5'h19;
         5'h16: r = 5'h1A;
         5'h17: r = 5'h1B;
         5'h1A: r = 5'h1C;
         5'h1B: r = 5'h1D;
         5'h1C: r = 5'h1E;
         5'h1D: r = 5'h1F;
         default: r = 5'h00;
      endcase
      return r;
   endfunction : decGrp

   // ================================================================
   // transmit: group sequencing and serial shifter
   fepc_tx_state_t txSt, next_txSt;
   logic [2:0] txCnt, next_txCnt;
   logic [4:0] txSh, next_txSh;
   logic next_txCodeBit;
   logic next_txNrzi;
   fepc_mlt_state_t mltSt, next_mltSt;
   logic txBoundary;
   logic scrKey;

   assign txBoundary = (txCnt == `FEPC_GROUP_LAST);
   // the mac must present the next nibble only after this pulse
   assign txNibbleTake = txBoundary && txEn && (txSt != TX_ESD);

   fepc_lfsr #(.WIDTH(`FEPC_LFSR_W)) scrambler (
      .clk(clk),
      .srst(srst),
      .seed({~mgmtAddr, 1'b1, mgmtAddr}),
      .trainEn(1'b0),
      .trainBit(1'b0),
      .keyBit(scrKey)
   );

   always_comb begin
      next_txSt = txSt;
      next_txCnt = txBoundary ? 3'h0 : txCnt + 3'h1;
      next_txSh = {txSh[3:0], 1'b0};
      if (txBoundary) begin
         case (txSt)
            TX_IDLE: begin
               if (txEn) begin
                  next_txSh = `FEPC_CG_SSD1;
                  next_txSt = TX_SSD;
               end else if (txLpi) begin
                  next_txSh = `FEPC_CG_SLEEP;
               end else begin
                  next_txSh = `FEPC_CG_IDLE;
               end
            end
            TX_SSD: begin
               next_txSh = `FEPC_CG_SSD2;
               next_txSt = TX_DATA;
            end
            TX_DATA: begin
               if (!txEn) begin
                  next_txSh = `FEPC_CG_ESD1;
                  next_txSt = TX_ESD;
               end else if (txEr) begin
                  next_txSh = `FEPC_CG_TXERR;
               end else begin
                  next_txSh = encNib(txd);
               end
            end
            TX_ESD: begin
               next_txSh = `FEPC_CG_ESD2;
               next_txSt = TX_IDLE;
            end
            default: begin
               next_txSh = `FEPC_CG_IDLE;
               next_txSt = TX_IDLE;
            end
         endcase
      end
      // serial out, left bit first, scrambled per bit
      next_txCodeBit = txSh[4] ^ scrKey;
      next_txNrzi = txNrzi ^ next_txCodeBit;
      next_mltSt = mltSt;
      if (next_txCodeBit) begin
         case (mltSt)
            MLT_ZERO_UP: next_mltSt = MLT_POS;
            MLT_POS: next_mltSt = MLT_ZERO_DN;
            MLT_ZERO_DN: next_mltSt = MLT_NEG;
            MLT_NEG: next_mltSt = MLT_ZERO_UP;
            default: next_mltSt = MLT_ZERO_UP;
         endcase
      end
      if (srst) begin
         next_txSt = TX_IDLE;
         next_txCnt = 3'h0;
         next_txSh = `FEPC_CG_IDLE;
         next_txCodeBit = 1'b0;
         next_txNrzi = 1'b0;
         next_mltSt = MLT_ZERO_UP;
      end
   end

   always_ff @(posedge clk) begin
      txSt <= next_txSt;
      txCnt <= next_txCnt;
      txSh <= next_txSh;
      txCodeBit <= next_txCodeBit;
      txNrzi <= next_txNrzi;
      mltSt <= next_mltSt;
   end

   // level code: 00 zero, 01 positive, 11 negative
   assign txMlt3 = (mltSt == MLT_POS) ? 2'h1 :
                   (mltSt == MLT_NEG) ? 2'h3 : 2'h0;

   // ================================================================
   // receive: line sync, mlt-3 to code bits, descrambler lock
   logic [1:0] rxM1, rxM2, rxM3;
   logic rxBit;
   logic dsKey;
   logic plain;
   logic next_rxLocked;
   logic [5:0] matchCnt, next_matchCnt;
   logic [3:0] onesRun, next_onesRun;
   logic [31:0] idleTmr, next_idleTmr;
   logic idleSeen;
   logic lockLost;

   // any level change is a one bit
   assign rxBit = (rxM2 != rxM3);
   assign plain = rxBit ^ dsKey;

   fepc_lfsr #(.WIDTH(`FEPC_LFSR_W)) descrambler (
      .clk(clk),
      .srst(srst),
      .seed({`FEPC_LFSR_W{1'b0}}),
      .trainEn(!rxLocked),
      .trainBit(~rxBit),
      .keyBit(dsKey)
   );

   // the run counter saturates, so a long idle keeps the window open
   assign idleSeen = plain && (onesRun >= `FEPC_IDLE_RUN_BITS - 4'h1);
   assign lockLost = rxLocked &&
                     (idleTmr >= 32'(IDLE_WINDOW_CYC - 1));

   always_comb begin
      next_rxLocked = rxLocked;
      next_matchCnt = matchCnt;
      next_onesRun = onesRun;
      next_idleTmr = idleTmr;
      if (!rxLocked) begin
         // idle makes every plain bit one, so the line shows the inverted key
         next_matchCnt = (dsKey == ~rxBit) ? matchCnt + 6'h1 : 6'h0;
         if (next_matchCnt == `FEPC_LOCK_MATCHES) begin
            next_rxLocked = 1'b1;
         end
         next_idleTmr = 32'h0;
         next_onesRun = 4'h0;
      end else begin
         next_onesRun = !plain ? 4'h0 :
            (onesRun == `FEPC_IDLE_RUN_BITS) ? onesRun : onesRun + 4'h1;
         next_idleTmr = idleSeen ? 32'h0 : idleTmr + 32'h1;
         if (lockLost) begin
            next_rxLocked = 1'b0;
            next_matchCnt = 6'h0;
         end
      end
      if (srst) begin
         next_rxLocked = 1'b0;
         next_matchCnt = 6'h0;
         next_onesRun = 4'h0;
         next_idleTmr = 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      rxM1 <= rxMlt3;
      rxM2 <= rxM1;
      rxM3 <= rxM2;
      rxLocked <= next_rxLocked;
      matchCnt <= next_matchCnt;
      onesRun <= next_onesRun;
      idleTmr <= next_idleTmr;
   end

   // ================================================================
   // receive: alignment and 5b/4b decode
   fepc_rx_state_t rxSt, next_rxSt;
   logic [9:0] rxWin, next_rxWin;
   logic [2:0] rxPh, next_rxPh;
   logic [3:0] pend, next_pend;
   logic [3:0] next_rxd;
   logic next_rxDv, next_rxEr, next_rxCrs, next_rxNibbleStb, next_rxSleep;
   logic idleOnce, next_idleOnce;
   logic [4:0] grp;
   logic [4:0] dec;
   logic rxBoundary;

   assign next_rxWin = {rxWin[8:0], plain};
   assign grp = next_rxWin[4:0];
   assign dec = decGrp(grp);
   assign rxBoundary = (rxPh == `FEPC_GROUP_LAST);

   always_comb begin
      next_rxSt = rxSt;
      next_rxPh = rxBoundary ? 3'h0 : rxPh + 3'h1;
      next_pend = pend;
      next_rxd = rxd;
      next_rxDv = rxDv;
      next_rxEr = rxBoundary ? 1'b0 : rxEr;
      next_rxCrs = rxCrs;
      next_rxNibbleStb = 1'b0;
      next_rxSleep = 1'b0;
      next_idleOnce = idleOnce;
      case (rxSt)
         RX_HUNT: begin
            if (rxLocked && next_rxWin == {`FEPC_CG_IDLE, `FEPC_CG_SSD1}) begin
               next_rxSt = RX_GOTJ;
               next_rxPh = 3'h0;
               next_rxCrs = 1'b1;
            end else if (rxLocked &&
                         next_rxWin == {`FEPC_CG_IDLE, `FEPC_CG_SLEEP}) begin
               next_rxSleep = 1'b1;
            end
         end
         RX_GOTJ: begin
            // idle into sleep mimics J two bits early; not a bad start
            if (next_rxWin == {`FEPC_CG_IDLE, `FEPC_CG_SLEEP}) begin
               next_rxSleep = 1'b1;
               next_rxCrs = 1'b0;
               next_rxSt = RX_HUNT;
            end else if (rxBoundary) begin
               next_rxNibbleStb = 1'b1;
               if (grp == `FEPC_CG_SSD2) begin
                  next_rxd = `FEPC_NIB_PREAMBLE;
                  next_pend = `FEPC_NIB_PREAMBLE;
                  next_rxDv = 1'b1;
                  next_idleOnce = 1'b0;
                  next_rxSt = RX_FRAME;
               end else begin
                  next_rxd = `FEPC_NIB_BADSSD;
                  next_rxEr = 1'b1;
                  next_rxCrs = 1'b0;
                  next_rxSt = RX_HUNT;
               end
            end
         end
         RX_FRAME: begin
            if (rxBoundary) begin
               next_rxNibbleStb = 1'b1;
               next_rxd = pend;
               next_idleOnce = 1'b0;
               if (dec[4]) begin
                  next_pend = dec[3:0];
               end else if (grp == `FEPC_CG_ESD1) begin
                  next_rxSt = RX_GOTT;
               end else if (grp == `FEPC_CG_IDLE && idleOnce) begin
                  next_rxDv = 1'b0;
                  next_rxCrs = 1'b0;
                  next_rxNibbleStb = 1'b0;
                  next_rxSt = RX_HUNT;
               end else begin
                  // invalid, lone R, idle or stray control
                  next_rxEr = 1'b1;
                  next_idleOnce = (grp == `FEPC_CG_IDLE);
               end
            end
         end
         RX_GOTT: begin
            if (rxBoundary) begin
               if (grp == `FEPC_CG_ESD2) begin
                  next_rxDv = 1'b0;
                  next_rxCrs = 1'b0;
                  next_rxSt = RX_HUNT;
               end else begin
                  next_rxNibbleStb = 1'b1;
                  next_rxEr = 1'b1;
                  next_rxSt = RX_FRAME;
               end
            end
         end
         default: begin
            next_rxSt = RX_HUNT;
         end
      endcase
      // a lost lock aborts the frame in progress
      if (lockLost) begin
         next_rxSt = RX_HUNT;
         next_rxDv = 1'b0;
         next_rxCrs = 1'b0;
      end
      if (srst) begin
         next_rxSt = RX_HUNT;
         next_rxPh = 3'h0;
         next_pend = 4'h0;
         next_rxd = 4'h0;
         next_rxDv = 1'b0;
         next_rxEr = 1'b0;
         next_rxCrs = 1'b0;
         next_rxSleep = 1'b0;
         next_idleOnce = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      rxSt <= next_rxSt;
      rxWin <= srst ? 10'h000 : next_rxWin;
      rxPh <= next_rxPh;
      pend <= next_pend;
      rxd <= next_rxd;
      rxDv <= next_rxDv;
      rxEr <= next_rxEr;
      rxCrs <= next_rxCrs;
      rxNibbleStb <= next_rxNibbleStb;
      rxSleep <= next_rxSleep;
      idleOnce <= next_idleOnce;
   end

endmodule : fepc_codec
`default_nettype wire

// [tb/fepc_codec_chk.sv]
// fepc_codec_chk: port assertions for the pcs codec
`timescale 1ns/1ps
`default_nettype none
`include "fepc_map.svh"
module fepc_codec_chk
   import fepc_pkg::*;
#(
   parameter int IDLE_WINDOW_CYC = `FEPC_IDLE_WINDOW_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // transmit
   input wire logic txEn,
   input wire logic txNibbleTake,
   input wire logic [1:0] txMlt3,
   input wire logic txCodeBit,
   input wire logic txNrzi,
   // receive
   input wire logic [3:0] rxd,
   input wire logic rxDv,
   input wire logic rxEr,
   input wire logic rxCrs,
   input wire logic rxNibbleStb,
   input wire logic rxSleep,
   input wire logic rxLocked
);
   // ==========
   // last non-zero level, so a step direction can be judged
   logic [1:0] lastLvl;
   logic [1:0] next_lastLvl;
   always_comb begin
      next_lastLvl = lastLvl;
      if (srst)
         next_lastLvl = 2'h0;
      else if (txMlt3 != 2'h0)
         next_lastLvl = txMlt3;
   end
   always_ff @(posedge clk) begin
      lastLvl <= next_lastLvl;
   end
   // ==========
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_take_gap; !txNibbleTake [*4]; endsequence
   sequence s_stb_gap; !rxNibbleStb [*4]; endsequence
   sequence s_er_group; rxEr [*5]; endsequence
   property p_reset_quiet;
      $fell(srst) |-> !rxDv && !rxCrs && !rxEr && !rxLocked &&
         txMlt3 == 2'h0;
   endproperty
   property p_take_gap; txNibbleTake |=> s_take_gap; endproperty
   property p_nrzi; txNrzi == ($past(txNrzi) ^ txCodeBit); endproperty
   property p_take_en; txNibbleTake |-> txEn; endproperty
   property p_mlt_step;
      $changed(txMlt3) |-> txMlt3 != 2'h2 &&
         (($past(txMlt3) == 2'h0) != (txMlt3 == 2'h0));
   endproperty
   property p_mlt_alt;
      (txMlt3 != 2'h0 && $past(txMlt3) == 2'h0 && lastLvl != 2'h0)
         |-> txMlt3 != lastLvl;
   endproperty
   property p_stb_gap; rxNibbleStb |=> s_stb_gap; endproperty
   property p_dv_start;
      $rose(rxDv) |-> rxNibbleStb && rxd == 4'h5 && rxCrs;
   endproperty
   property p_dv_lock; $rose(rxDv) |-> rxLocked; endproperty
   property p_er_group; $rose(rxEr) |-> rxNibbleStb ##0 s_er_group;
   endproperty
   property p_sleep_out; rxSleep |-> !rxDv && !rxCrs; endproperty
   property p_lock_loss;
      $fell(rxLocked) |-> ##[0:5] (!rxDv && !rxCrs);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet after reset");
   a_take_gap: assert property (p_take_gap)
      else $error("nibble takes closer than one group");
   a_nrzi: assert property (p_nrzi)
      else $error("line bit did not toggle on code one");
   a_take_en: assert property (p_take_en)
      else $error("nibble taken with enable low");
   a_mlt_step: assert property (p_mlt_step)
      else $error("line level jumped past zero");
   a_mlt_alt: assert property (p_mlt_alt)
      else $error("line level repeated its last polarity");
   a_stb_gap: assert property (p_stb_gap)
      else $error("receive strobes off group alignment");
   a_dv_start: assert property (p_dv_start)
      else $error("data valid rose without preamble nibble");
   a_dv_lock: assert property (p_dv_lock)
      else $error("data valid rose while unlocked");
   a_er_group: assert property (p_er_group)
      else $error("receive error not one full group");
   a_sleep_out: assert property (p_sleep_out)
      else $error("sleep flagged inside a frame");
   a_lock_loss: assert property (p_lock_loss)
      else $error("frame kept after lock loss");
endmodule : fepc_codec_chk

bind fepc_codec fepc_codec_chk #(
   .IDLE_WINDOW_CYC(IDLE_WINDOW_CYC)
) u_fepc_codec_chk (
   .clk(clk),
   .srst(srst),
   .txEn(txEn),
   .txNibbleTake(txNibbleTake),
   .txMlt3(txMlt3),
   .txCodeBit(txCodeBit),
   .txNrzi(txNrzi),
   .rxd(rxd),
   .rxDv(rxDv),
   .rxEr(rxEr),
   .rxCrs(rxCrs),
   .rxNibbleStb(rxNibbleStb),
   .rxSleep(rxSleep),
   .rxLocked(rxLocked)
);
`default_nettype wire

// [tb/fepc_mac_model.sv]
// fepc_mac_model: mac behind the internal mii, sends and gathers nibbles
`timescale 1ns/1ps
`default_nettype none
module fepc_mac_model (
   // clock
   input wire logic clk,
   // transmit toward the codec
   output logic [3:0] txd,
   output logic txEn,
   output logic txEr,
   input wire logic txNibbleTake,
   // receive from the codec
   input wire logic [3:0] rxd,
   input wire logic rxDv,
   input wire logic rxEr,
   input wire logic rxNibbleStb,
   input wire logic rxSleep,
   input wire logic rxLocked
);
   logic [3:0] rxq[$];
   int erCount = 0;
   int sleepCount = 0;
   int lockFalls = 0;
   logic lastEr = 1'b0;
   logic lastLocked = 1'b0;
   initial begin
      txd = 4'h0;
      txEn = 1'b0;
      txEr = 1'b0;
   end
   // two preamble nibbles lead, the encoder swaps them for the start pair
   task automatic send_frame(input logic [3:0] data[$], input int errAt);
      logic [3:0] q[$];
      int i;
      q = data;
      q.push_front(4'h5);
      q.push_front(4'h5);
      i = 0;
      @(posedge clk);
      txd <= q[0];
      txEr <= (errAt == 0);
      txEn <= 1'b1;
      while (i < q.size()) begin
         @(posedge clk);
         if (txNibbleTake === 1'b1) begin
            i++;
            if (i < q.size()) begin
               txd <= q[i];
               txEr <= (i == errAt);
            end else begin
               txEn <= 1'b0;
               txEr <= 1'b0;
            end
         end
      end
   endtask : send_frame
   always @(posedge clk) begin
      if (rxNibbleStb === 1'b1 && rxDv === 1'b1)
         rxq.push_back(rxd);
      if (rxEr === 1'b1 && !lastEr)
         erCount++;
      if (rxSleep === 1'b1)
         sleepCount++;
      if (lastLocked && rxLocked !== 1'b1)
         lockFalls++;
      lastEr <= (rxEr === 1'b1);
      lastLocked <= (rxLocked === 1'b1);
   end
endmodule : fepc_mac_model
`default_nettype wire

// [tb/test_fepc_codec.sv]
// test_fepc_codec: self-checking bench, line side looped onto itself
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD %0t got %h want %h", $time, got, exp); \
   end \
end
module test_fepc_codec;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] mgmtAddr = 5'h01;
   logic txLpi = 1'b0;
   logic [1:0] rxMlt3 = 2'h0;
   logic [3:0] txd, rxd;
   logic txEn, txEr, txNibbleTake, txCodeBit, txNrzi;
   logic [1:0] txMlt3;
   logic rxDv, rxEr, rxCrs, rxNibbleStb, rxSleep, rxLocked;
   int mismatches = 0;
   int checks = 0;
   always #2.5 clk = ~clk;
   // short idle window keeps the abort case quick
   fepc_codec #(.IDLE_WINDOW_CYC(200)) u_fepc_codec (.clk(clk),
      .srst(srst), .mgmtAddr(mgmtAddr), .txd(txd), .txEn(txEn),
      .txEr(txEr), .txLpi(txLpi), .txNibbleTake(txNibbleTake),
      .txCodeBit(txCodeBit), .txNrzi(txNrzi), .txMlt3(txMlt3),
      .rxMlt3(rxMlt3), .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr),
      .rxCrs(rxCrs), .rxNibbleStb(rxNibbleStb), .rxSleep(rxSleep),
      .rxLocked(rxLocked));
   fepc_mac_model u_fepc_mac_model (.clk(clk), .txd(txd), .txEn(txEn),
      .txEr(txEr), .txNibbleTake(txNibbleTake), .rxd(rxd), .rxDv(rxDv),
      .rxEr(rxEr), .rxNibbleStb(rxNibbleStb), .rxSleep(rxSleep),
      .rxLocked(rxLocked));
   always @(posedge clk) rxMlt3 <= txMlt3;
   // ==========
   task automatic wait_lock();
      int n;
      n = 0;
      while (rxLocked !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHECK(rxLocked, 1'b1)
   endtask : wait_lock
   task automatic wait_rx();
      int n;
      n = 0;
      while (rxCrs !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      while ((rxDv !== 1'b0 || rxCrs !== 1'b0) && n < 800) begin
         @(posedge clk);
         n++;
      end
      `CHECK({rxDv, rxCrs}, 2'h0)
   endtask : wait_rx
   task automatic idle_bits(input logic [4:0] addr, output logic [31:0] b);
      mgmtAddr <= addr;
      srst <= 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      `CHECK({rxDv, rxCrs, rxEr, rxLocked, txMlt3}, 6'h00)
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         b[i] = txCodeBit;
      end
   endtask : idle_bits
   // ==========
   task automatic test_seed();
      logic [31:0] a, b;
      idle_bits(5'h01, a);
      idle_bits(5'h02, b);
      `CHECK(a != b, 1'b1)
      wait_lock();
   endtask : test_seed
   task automatic test_frame();
      logic [3:0] q[$];
      for (int i = 0; i < 16; i++) q.push_back(i[3:0]);
      u_fepc_mac_model.rxq.delete();
      u_fepc_mac_model.send_frame(q, -1);
      wait_rx();
      `CHECK(u_fepc_mac_model.rxq.size(), 18)
      for (int i = 0; i < 18; i++)
         `CHECK(u_fepc_mac_model.rxq[i], (i < 2) ? 4'h5 : 4'(i - 2))
      `CHECK(u_fepc_mac_model.erCount, 0)
   endtask : test_frame
   task automatic test_tx_error();
      logic [3:0] q[$];
      int e0;
      q = {4'hA, 4'hB, 4'hC};
      e0 = u_fepc_mac_model.erCount;
      u_fepc_mac_model.send_frame(q, 3);
      wait_rx();
      `CHECK(u_fepc_mac_model.erCount - e0, 1)
   endtask : test_tx_error
   task automatic test_sleep();
      int s0, n, e0;
      s0 = u_fepc_mac_model.sleepCount;
      e0 = u_fepc_mac_model.erCount;
      n = 0;
      @(posedge clk);
      txLpi <= 1'b1;
      while (u_fepc_mac_model.sleepCount == s0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      txLpi <= 1'b0;
      `CHECK(u_fepc_mac_model.sleepCount > s0, 1'b1)
      wait_lock();
      `CHECK(u_fepc_mac_model.erCount - e0, 0)
   endtask : test_sleep
   task automatic test_window();
      logic [3:0] q[$];
      int e0, l0;
      for (int i = 0; i < 60; i++) q.push_back(4'h3);
      e0 = u_fepc_mac_model.erCount;
      l0 = u_fepc_mac_model.lockFalls;
      u_fepc_mac_model.rxq.delete();
      u_fepc_mac_model.send_frame(q, -1);
      wait_rx();
      `CHECK(u_fepc_mac_model.lockFalls > l0, 1'b1)
      `CHECK(u_fepc_mac_model.rxq.size() < 62, 1'b1)
      `CHECK(u_fepc_mac_model.erCount - e0, 0)
      wait_lock();
   endtask : test_window
   // ==========
   task complete_run();
      if (mismatches == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      wait_lock();
      test_seed();
      test_frame();
      test_tx_error();
      test_sleep();
      test_window();
      complete_run();
   end
   // all tests need under a thousand cycles; this is twenty times that
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule : test_fepc_codec
`default_nettype wire
